// file: rtl/acc_conv_clock.sv
// Conversion clock selection, conversion sequencing and analog pin handling of an 8-bit converter.
// Functional notes
// - A full 8-bit conversion takes ten and a half bit times.
// - Select 00/01/10 gives 2/8/32 oscillator periods per bit; 11 picks RC.
// - RC bit time is about 4 us, within 2 to 6 us, oscillator independent.
// - An output pin selected for conversion converts its own driven level.
// - Channel select and direction bits never block or alter the sequence.
// - Port reads return zero for pins configured as analog inputs.
// - A digital input pin is still converted like an analog pin.
// - Acquisition time is the same whatever resolution is used.
// - Bits resolved after switching below minimum bit time are marked invalid.
// - Truncated time is two plus N bit times plus (8-N) two-oscillator periods.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "acc_defs.svh"
module acc_conv_clock
	import acc_pkg::*;
#(
	parameter int NCHAN = 8,
	parameter int RC_TAD_CYC = `ACC_RC_TAD_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] input_channel_select,
	input wire logic [7:0] pin_level,
	input wire logic [7:0] pin_drive,
	input wire logic comparator_high,
	output logic [2:0] sample_channel,
	output logic sample_from_drive,
	output logic [7:0] trial_code,
	output logic busy
);
	acc_state_s st_r;
	acc_state_s st_nxt;
	logic [11:0] tad_cyc;
	logic tad_tick;
	logic [7:0] port_value;

	// Only eight channels fit the port and the channel field; the RC count must fit the 12-bit tick counter.
	if (NCHAN != 8 || RC_TAD_CYC < 2 || RC_TAD_CYC > 4095) begin : g_bad_params
		$error("acc_conv_clock: unsupported parameter values");
	end

	// RC bit time fixed in aclk cycles, so it does not track the oscillator setting.
	always_comb begin
		unique case (st_r.sel)
			2'h0: tad_cyc = 12'(2 * `ACC_TOSC_PER_CLK);
			2'h1: tad_cyc = 12'(8 * `ACC_TOSC_PER_CLK);
			2'h2: tad_cyc = 12'(32 * `ACC_TOSC_PER_CLK);
			2'h3: tad_cyc = 12'(RC_TAD_CYC);
		endcase
	end

	// per-bit clock reselect
	// The bit time is looked up afresh every cycle, so a faster setting written mid-conversion
	// shortens the remaining bits; the greater-or-equal test ends a bit at once if the count overshoots.
	assign tad_tick = (st_r.phase != ACC_IDLE) && (st_r.tick + 12'h001 >= tad_cyc);

	assign port_value = pin_level & ~st_r.analog_cfg;

	// Next-state logic: bus slave, control registers and conversion sequencer.
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.awv = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.wv = 1'b1;
			st_nxt.wdata = s_axi_wdata;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// Write completes once both address and data are held.
		if (st_r.awv && st_r.wv && !st_r.bvalid) begin
			st_nxt.awv = 1'b0;
			st_nxt.wv = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = `ACC_RESP_OKAY;
			unique case (st_r.awaddr[7:2])
				6'(`ACC_OFF_CTRL >> 2): begin
					if (s_axi_wstrb[0]) begin
						st_nxt.sel = st_r.wdata[`ACC_CTRL_SEL_HI:`ACC_CTRL_SEL_LO];
						if (st_r.wdata[`ACC_CTRL_GO] && st_r.phase == ACC_IDLE) begin
							st_nxt.go = 1'b1;
						end
					end
				end
				6'(`ACC_OFF_DIR >> 2): begin
					if (s_axi_wstrb[0]) begin
						st_nxt.port_dir = st_r.wdata[7:0];
					end
				end
				6'(`ACC_OFF_ANA >> 2): begin
					if (s_axi_wstrb[0]) begin
						st_nxt.analog_cfg = st_r.wdata[7:0];
					end
				end
				6'(`ACC_OFF_STAT >> 2), 6'(`ACC_OFF_PORT >> 2): begin
					st_nxt.bresp = `ACC_RESP_OKAY;
				end
				default: st_nxt.bresp = `ACC_RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = `ACC_RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			unique case (s_axi_araddr[7:2])
				6'(`ACC_OFF_CTRL >> 2): st_nxt.rdata[`ACC_CTRL_SEL_HI:0] = {st_r.sel, st_r.go};
				6'(`ACC_OFF_STAT >> 2): st_nxt.rdata = {8'h00, st_r.valid_mask, st_r.result, 7'h00, busy};
				6'(`ACC_OFF_PORT >> 2): st_nxt.rdata[7:0] = port_value;
				6'(`ACC_OFF_DIR >> 2): st_nxt.rdata[7:0] = st_r.port_dir;
				6'(`ACC_OFF_ANA >> 2): st_nxt.rdata[7:0] = st_r.analog_cfg;
				default: st_nxt.rresp = `ACC_RESP_SLVERR;
			endcase
		end
		// Comparator output passes three flops; the filtered level moves only when stages two and three agree.
		// The chain costs four cycles of latency, so the shortest divided bit time cannot resolve reliably.
		st_nxt.pin_s1 = {st_r.pin_s1[1:0], comparator_high};
		if (st_r.pin_s1[1] == st_r.pin_s1[2]) begin
			st_nxt.pin_s2[0] = st_r.pin_s1[2];
		end
		st_nxt.pin_s2[2:1] = 2'b00;
		// Previous filtered level, kept so the filter can be checked.
		st_nxt.pin_s3 = st_r.pin_s2;
		// sequence ignores channel and direction bits
		if (st_r.phase != ACC_IDLE) begin
			st_nxt.tick = tad_tick ? 12'h000 : st_r.tick + 12'h001;
		end
		unique case (st_r.phase)
			ACC_IDLE: begin
				if (st_r.go) begin
					st_nxt.go = 1'b0;
					st_nxt.phase = ACC_ACQ;
					st_nxt.tick = 12'h000;
					st_nxt.bitn = 4'h0;
					st_nxt.sar = 8'h80;
					st_nxt.valid_mask = 8'h00;
				end
			end
			// acquisition fixed at two bit times
			ACC_ACQ: begin
				if (tad_tick) begin
					st_nxt.bitn = st_r.bitn + 4'h1;
					if (st_r.bitn + 4'h1 == 4'(`ACC_ACQ_TADS)) begin
						st_nxt.phase = ACC_BITS;
						st_nxt.bitn = 4'h7;
					end
				end
			end
			ACC_BITS: begin
				if (tad_tick) begin
					st_nxt.sar[st_r.bitn[2:0]] = st_r.pin_s2[0];
					if (st_r.bitn != 4'h0) begin
						st_nxt.sar[st_r.bitn[2:0] - 3'h1] = 1'b1;
					end
					// bits under short bit time invalid
					st_nxt.valid_mask[st_r.bitn[2:0]] = tad_cyc >= 12'(`ACC_TAD_MIN_CYC);
					if (st_r.bitn == 4'h0) begin
						st_nxt.phase = ACC_HALF;
					end else begin
						st_nxt.bitn = st_r.bitn - 4'h1;
					end
				end
			end
			ACC_HALF: begin
				if (st_r.tick + 12'h001 >= (tad_cyc >> 1)) begin
					st_nxt.phase = ACC_IDLE;
					st_nxt.tick = 12'h000;
					st_nxt.result = st_r.sar;
					st_nxt.done = 1'b1;
				end
			end
		endcase
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '{default: '0, port_dir: `ACC_DIR_RESET, phase: ACC_IDLE};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready = !st_r.awv;
	assign s_axi_wready = !st_r.wv;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign busy = st_r.phase != ACC_IDLE;
	assign trial_code = st_r.sar;
	// output pin converts its driven level
	assign sample_channel = input_channel_select;
	assign sample_from_drive = !st_r.port_dir[input_channel_select];

	// Assertions.
	int unsigned conv_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || st_r.phase == ACC_IDLE) begin
			conv_cnt <= 0;
		end else begin
			conv_cnt <= conv_cnt + 1;
		end
	end

	property p_full_time;
		@(posedge aclk) disable iff (!aresetn)
			(st_r.done && st_r.sel == 2'h2) |-> conv_cnt == (`ACC_CONV_HALF_TADS * 32 * `ACC_TOSC_PER_CLK) / 2;
	endproperty
	a_full_time: assert property (p_full_time) else $error("conversion time wrong");

	// Busy must still stand well into a 32-period conversion.
	property p_len_32;
		@(posedge aclk) disable iff (!aresetn) $rose(busy) && st_r.sel == 2'h2 |-> ##300 busy;
	endproperty
	a_len_32: assert property (p_len_32) else $error("32 period conversion length wrong");

	property p_sel_map;
		@(posedge aclk) disable iff (!aresetn) st_r.sel == 2'h1 |-> tad_cyc == 12'h008;
	endproperty
	a_sel_map: assert property (p_sel_map) else $error("bit time map wrong");

	property p_rc;
		@(posedge aclk) disable iff (!aresetn) st_r.sel == `ACC_SEL_RC |-> tad_cyc >= 12'd200 && tad_cyc <= 12'd600;
	endproperty
	a_rc: assert property (p_rc) else $error("RC bit time out of range");

	property p_drive;
		@(posedge aclk) disable iff (!aresetn) !st_r.port_dir[input_channel_select] |-> sample_from_drive;
	endproperty
	a_drive: assert property (p_drive) else $error("output pin not converted from drive");

	property p_port_zero;
		@(posedge aclk) disable iff (!aresetn)
			s_axi_arvalid && s_axi_arready && s_axi_araddr == `ACC_OFF_PORT |=> (s_axi_rdata[7:0] & $past(st_r.analog_cfg)) == 8'h00;
	endproperty
	a_port_zero: assert property (p_port_zero) else $error("analog pin read nonzero");

	property p_acq;
		@(posedge aclk) disable iff (!aresetn) $rose(busy) && st_r.sel == 2'h0 |-> busy [*4] ##1 st_r.phase == ACC_BITS;
	endproperty
	a_acq: assert property (p_acq) else $error("acquisition length wrong");

	property p_invalid;
		@(posedge aclk) disable iff (!aresetn) st_r.phase == ACC_BITS && tad_tick && st_r.sel == 2'h0 |=> !st_r.valid_mask[$past(st_r.bitn[2:0])];
	endproperty
	a_invalid: assert property (p_invalid) else $error("short bit time marked valid");

	property p_msb;
		@(posedge aclk) disable iff (!aresetn) $rose(st_r.phase == ACC_BITS) |-> st_r.bitn == 4'h7 && st_r.sar == 8'h80;
	endproperty
	a_msb: assert property (p_msb) else $error("resolution not MSB first");

	// The trailing half bit follows the last resolved bit directly.
	property p_half;
		@(posedge aclk) disable iff (!aresetn) st_r.phase == ACC_BITS && tad_tick && st_r.bitn == 4'h0 |=> st_r.phase == ACC_HALF;
	endproperty
	a_half: assert property (p_half) else $error("half bit time missing");

	property p_bit_count;
		@(posedge aclk) disable iff (!aresetn) st_r.phase == ACC_BITS |-> st_r.bitn <= 4'h7;
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("bit index out of range");

	// With the eight-period setting held, every bit lasts exactly eight cycles.
	property p_bit_period;
		@(posedge aclk) disable iff (!aresetn) tad_tick && st_r.sel == 2'h1 && $stable(st_r.sel) |-> st_r.tick == 12'h007;
	endproperty
	a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

	property p_go_busy;
		@(posedge aclk) disable iff (!aresetn) st_r.go |=> busy;
	endproperty
	a_go_busy: assert property (p_go_busy) else $error("start did not begin a conversion");

	property p_acq_bitn;
		@(posedge aclk) disable iff (!aresetn) st_r.phase == ACC_ACQ |-> st_r.bitn < 4'(`ACC_ACQ_TADS);
	endproperty
	a_acq_bitn: assert property (p_acq_bitn) else $error("acquisition overran");

	property p_valid_rc;
		@(posedge aclk) disable iff (!aresetn)
			st_r.phase == ACC_BITS && tad_tick && st_r.sel == `ACC_SEL_RC |=> st_r.valid_mask[$past(st_r.bitn[2:0])];
	endproperty
	a_valid_rc: assert property (p_valid_rc) else $error("RC bit marked invalid");

	// The filtered comparator level may only move after stages two and three agreed.
	property p_sync;
		@(posedge aclk) disable iff (!aresetn)
			st_r.pin_s2[0] != st_r.pin_s3[0] |-> $past(st_r.pin_s1[1] == st_r.pin_s1[2]);
	endproperty
	a_sync: assert property (p_sync) else $error("comparator filter moved without agreement");

	property p_result;
		@(posedge aclk) disable iff (!aresetn) st_r.done |-> st_r.result == $past(st_r.sar);
	endproperty
	a_result: assert property (p_result) else $error("result not taken from trial register");

	// Responses stand until the master takes them.
	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

	property p_rvalid_hold;
		@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");

	c_done: cover property (@(posedge aclk) disable iff (!aresetn) st_r.done);
	c_rc: cover property (@(posedge aclk) disable iff (!aresetn) st_r.done && st_r.sel == `ACC_SEL_RC);
	c_trunc: cover property (@(posedge aclk) disable iff (!aresetn) st_r.done && st_r.valid_mask != 8'hFF && st_r.valid_mask != 8'h00);
	c_drive: cover property (@(posedge aclk) disable iff (!aresetn) st_r.done && sample_from_drive);
endmodule : acc_conv_clock

// file: rtl/acc_defs.svh
// Register offsets, field positions, reset values and timing constants of the conversion clock block.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_OFF_CTRL 8'h00
`define ACC_OFF_STAT 8'h04
`define ACC_OFF_PORT 8'h08
`define ACC_OFF_DIR 8'h0C
`define ACC_OFF_ANA 8'h10
`define ACC_CTRL_GO 0
`define ACC_CTRL_SEL_LO 1
`define ACC_CTRL_SEL_HI 2
`define ACC_SEL_RC 2'h3
`define ACC_TOSC_PER_CLK 1
`define ACC_RC_TAD_NS 4000
`define ACC_CLK_NS 10
`define ACC_RC_TAD_CYC ((`ACC_RC_TAD_NS) / (`ACC_CLK_NS))
`define ACC_TAD_MIN_NS 1600
`define ACC_TAD_MIN_CYC (((`ACC_TAD_MIN_NS) + (`ACC_CLK_NS) - 1) / (`ACC_CLK_NS))
`define ACC_ACQ_TADS 2
`define ACC_CONV_HALF_TADS 21
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2
`define ACC_DIR_RESET 8'hFF
`endif

// file: rtl/acc_pkg.sv
// Types shared by the conversion clock block.
package acc_pkg;
	typedef enum logic [1:0] {ACC_IDLE, ACC_ACQ, ACC_BITS, ACC_HALF} acc_phase_e;
	typedef struct packed {
		logic awv;
		logic wv;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic go;
		logic [1:0] sel;
		logic [7:0] port_dir;
		logic [7:0] analog_cfg;
		acc_phase_e phase;
		logic [11:0] tick;
		logic [3:0] bitn;
		logic [7:0] sar;
		logic [7:0] result;
		logic [7:0] valid_mask;
		logic done;
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [2:0] pin_s3;
	} acc_state_s;
endpackage : acc_pkg

// file: tb/acc_src_model.sv
// Analog sources on the converter inputs, seen through the comparator.
`timescale 1ns/1ns
module acc_src_model (
	input wire logic aclk,
	input wire logic [2:0] sample_channel,
	input wire logic sample_from_drive,
	input wire logic [7:0] pin_drive,
	input wire logic [63:0] levels,
	input wire logic [7:0] trial_code,
	output logic comparator_high = 1'b0
);
	logic [7:0] vin;
	// An output pin offers its own rail level; any other pin offers its voltage.
	always_comb vin = sample_from_drive ? {8{pin_drive[sample_channel]}} : levels[sample_channel * 8 +: 8];
	// The comparator settles one clock late, so the design must not sample too early.
	always @(posedge aclk) comparator_high <= (vin >= trial_code);
endmodule : acc_src_model

// file: tb/tb.sv
// Self-checking bench of the conversion clock block.
`timescale 1ns/1ns
module tb;
	import acc_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic [7:0] awa = 8'h00, ara = 8'h00, plev = 8'h00, pdrv = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [2:0] chan = 3'h0;
	logic [63:0] lvl = 64'hC3_3C_81_7E_96_69_FF_5A;
	logic [1:0] resp;
	wire logic awr, wr, bv, arr, rv, cmp, sfd, busy;
	wire logic [1:0] br, rr;
	wire logic [31:0] rdat;
	wire logic [2:0] schan;
	wire logic [7:0] trial;
	int failures = 0, samples_checked = 0, cyc = 0;
	acc_conv_clock uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.input_channel_select(chan), .pin_level(plev), .pin_drive(pdrv), .comparator_high(cmp),
		.sample_channel(schan), .sample_from_drive(sfd), .trial_code(trial), .busy(busy));
	acc_src_model src (.aclk(aclk), .sample_channel(schan), .sample_from_drive(sfd), .pin_drive(pdrv),
		.levels(lvl), .trial_code(trial), .comparator_high(cmp));
	always #5 aclk = ~aclk;
	task report_and_stop;
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// A hung handshake ends the run here.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			report_and_stop;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Ready is read at the falling edge, where it already shows what the next rising edge samples.
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw;
		pa = 1;
		pw = 1;
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && awr;
			tw = pw && wr;
			@(posedge aclk);
			if (ta) begin
				awv <= 0;
				pa = 0;
			end
			if (tw) begin
				wv <= 0;
				pw = 0;
			end
		end
		do begin
			@(negedge aclk);
			ta = bv;
			resp = br;
			@(posedge aclk);
		end while (ta !== 1'b1);
		bry <= 0;
	endtask : axw
	task axr(input logic [7:0] a);
		logic t;
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do begin
			@(negedge aclk);
			t = arr;
			@(posedge aclk);
		end while (t !== 1'b1);
		arv <= 0;
		do begin
			@(negedge aclk);
			t = rv;
			rd = rdat;
			resp = rr;
			@(posedge aclk);
		end while (t !== 1'b1);
		rry <= 0;
	endtask : axr
	// One conversion: length of busy, result and valid mask; the bench times it by counting cycles.
	// the clock setting is held through the whole conversion
	task conv(input logic [1:0] sel, input int conversion_bit_time, input logic [7:0] ex, input logic [7:0] em);
		int n, e;
		e = 10 * conversion_bit_time + conversion_bit_time / 2;
		axw(8'h00, {29'h0, sel, 1'b1});
		@(negedge aclk);
		n = 0;
		while (busy === 1'b1) begin
			@(negedge aclk);
			n++;
		end
		chk("busy_len", e, n);
		axr(8'h04);
		chk("result", ex, rd[15:8]);
		chk("valid_mask", em, rd[23:16]);
	endtask : conv
	task t_regs;
		axr(8'h0C);
		chk("dir_reset", 32'hFF, rd);
		axr(8'h14);
		chk("unmapped_resp", 2'h2, resp);
		axw(8'h10, 32'h0F);
		plev <= 8'hFF;
		axr(8'h08);
		chk("port_read", 32'hF0, rd);
		axw(8'h10, 32'h00);
	endtask : t_regs
	// Divided clocks are all below the minimum bit time at this clock rate; the fastest one sees a full-scale
	// level, because its bit time is shorter than the comparator filter latency.
	task t_div;
		int tads[3];
		tads = '{2, 8, 32};
		for (int s = 0; s < 3; s++) begin
			chan <= 3'(s + 1);
			conv(2'(s), tads[s], lvl[(s + 1) * 8 +: 8], 8'h00);
		end
	endtask : t_div
	// the RC clock is used for a single conversion only
	task t_rc;
		chan <= 3'h7;
		conv(2'h3, 400, 8'hC3, 8'hFF);
	endtask : t_rc
	task t_drive;
		axw(8'h0C, 32'hFE);
		chan <= 3'h0;
		pdrv <= 8'h01;
		@(negedge aclk);
		chk("from_drive", 1, sfd);
		chk("sample_channel", 3'h0, schan);
		conv(2'h1, 8, 8'hFF, 8'h00);
		pdrv <= 8'h00;
		conv(2'h1, 8, 8'h00, 8'h00);
		axw(8'h0C, 32'hFF);
	endtask : t_drive
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_div;
		t_rc;
		t_drive;
		report_and_stop;
	end
endmodule : tb
